// >>> cstx_top.sv
/*
 Bus module status and dedicated transmit buffer control.
 Assumes a bus engine that reports per-buffer events as one-cycle pulses
 and an 8-bit register port with read data one cycle after the strobe.
*/
// Overview of operation
// - Mode bits 7:5: 100 config, 011 listen, 010 loop, 001 off, 000 run.
// - Pending interrupts show one prioritized code for the top source; legacy shows wake as error, buffers as none.
// - Legacy mode: 3-bit code in bits 3:1; RX1 01010, RX0 01100.
// - Enhanced and FIFO modes: full 5-bit code in bits 4:0.
// - Common codes: none, error, TX2, TX1, TX0 as listed.
// - Enhanced: RX0 10000, RX1 10001, buffers 10010-10111, wake 01110.
// - FIFO: receivers report 10000; transmit buffers keep own code.
// - Window select maps chosen buffer; codes usable as selectors.
// - Done flag set on completion; software may only clear it.
// - Aborted flag set when pending message is aborted.
// - Three identical control registers; bit 2 reads zero.
// - Request clears status flags; cleared on success; clearing aborts.
// - Lost-arbitration flag set on loss, cleared by new request.
// - Error flag set on bus error, cleared by new request.
// - Pending buffers go in order of 2-bit priority, 11 highest.
module cstx_top
   import cstx_pkg::*;
(
   input  wire logic                 core_clk_i,
   input  wire logic                 sys_rst_i,
   input  wire logic [3:0]           addr_i,
   input  wire logic [7:0]           wdata_i,
   input  wire logic                 wr_i,
   input  wire logic                 rd_i,
   output logic [7:0]                rdata_o,
   input  wire logic [2:0]           tx_done_i,
   input  wire logic [2:0]           tx_abort_i,
   input  wire logic [2:0]           tx_larb_i,
   input  wire logic [2:0]           tx_err_i,
   input  wire logic                 err_irq_i,
   input  wire logic                 wake_irq_i,
   input  wire logic                 rx0_irq_i,
   input  wire logic                 rx1_irq_i,
   input  wire logic [5:0]           pb_irq_i,
   input  wire logic [5:0]           pb_is_tx_i,
   input  wire logic [2:0]           mode_status_i,
   output logic [2:0]                mode_req_o,
   output logic                      send_valid_o,
   output logic [1:0]                send_buf_o,
   output logic [2:0]                abort_req_o,
   output logic [4:0]                window_sel_o,
   output logic                      irq_o
);
   import cstx_pkg::*;

   // ------------------------------------------------------------------
   // Configuration and window registers
   // ------------------------------------------------------------------
   logic [2:0]  mode_req;
   logic [2:0]  next_mode_req;
   cstx_map_t   map_mode;
   cstx_map_t   next_map_mode;
   logic [4:0]  window;
   logic [4:0]  next_window;
   logic [13:0] irq_stat;
   logic [13:0] next_irq_stat;
   logic [13:0] irq_en;
   logic [13:0] next_irq_en;
   logic [7:0]  rdata;
   logic [7:0]  next_rdata;
   logic [2:0]  opmode;
   logic [2:0]  next_opmode;

   logic [7:0]  txcon [CSTX_NUM_TX];
   logic [2:0]  txcon_wr;
   logic [13:0] events;
   logic [4:0]  icode;
   cstx_src_t   src;

   // ------------------------------------------------------------------
   // Transmit buffer control registers
   // ------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < CSTX_NUM_TX; g++) begin : g_tx
         cstx_txev_t ev;
         assign ev.done  = tx_done_i[g];
         assign ev.abort = tx_abort_i[g];
         assign ev.larb  = tx_larb_i[g];
         assign ev.err   = tx_err_i[g];
         assign txcon_wr[g] = wr_i && addr_i == CSTX_ADDR_TXCON0 + 4'(g);
         cstx_txbuf u_txbuf (
            .core_clk_i  (core_clk_i),
            .sys_rst_i   (sys_rst_i),
            .wr_i        (txcon_wr[g]),
            .wdata_i     (wdata_i),
            .ev_i        (ev),
            .ctrl_o      (txcon[g]),
            .abort_req_o (abort_req_o[g])
         );
      end
   endgenerate

   // ------------------------------------------------------------------
   // Send arbitration
   // ------------------------------------------------------------------
   // Ties go to the higher buffer number, matching the code table order
   always_comb begin
      logic [1:0] best;
      best         = 2'b00;
      send_valid_o = 1'b0;
      send_buf_o   = 2'b00;
      for (int i = 0; i < CSTX_NUM_TX; i++) begin
         if (txcon[i][CSTX_BIT_REQ] && !abort_req_o[i] &&
             (!send_valid_o || txcon[i][1:0] >= best)) begin
            send_valid_o = 1'b1;
            send_buf_o   = 2'(i);
            best         = txcon[i][1:0];
         end
      end
   end

   // ------------------------------------------------------------------
   // Interrupt status
   // ------------------------------------------------------------------
   // Bit order: err, tx2..0, rx1, rx0, wake, pb5..0
   assign events = {err_irq_i, tx_done_i, rx1_irq_i, rx0_irq_i, wake_irq_i,
                    1'b0, pb_irq_i};

   assign src.err      = irq_stat[13];
   assign src.tx       = irq_stat[12:10];
   assign src.rx1      = irq_stat[9];
   assign src.rx0      = irq_stat[8];
   assign src.wake     = irq_stat[7];
   assign src.pb       = irq_stat[5:0];
   assign src.pb_is_tx = pb_is_tx_i;

   // Code reflects only enabled sources so the vector fits the handler
   cstx_src_t src_en;
   assign src_en.err      = src.err & irq_en[13];
   assign src_en.tx       = src.tx & irq_en[12:10];
   assign src_en.rx1      = src.rx1 & irq_en[9];
   assign src_en.rx0      = src.rx0 & irq_en[8];
   assign src_en.wake     = src.wake & irq_en[7];
   assign src_en.pb       = src.pb & irq_en[5:0];
   assign src_en.pb_is_tx = pb_is_tx_i;

   cstx_icode u_icode (
      .src_i  (src_en),
      .map_i  (map_mode),
      .code_o (icode)
   );

   // ------------------------------------------------------------------
   // Register next state
   // ------------------------------------------------------------------
   always_comb begin
      next_mode_req = mode_req;
      next_map_mode = map_mode;
      next_window   = window;
      next_irq_en   = irq_en;
      next_irq_stat = irq_stat;
      next_rdata    = 8'h00;
      next_opmode   = mode_status_i;
      if (wr_i) begin
         unique case (addr_i)
            CSTX_ADDR_CONFIG: begin
               next_mode_req = wdata_i[7:5];
               if (wdata_i[1:0] != 2'b11) begin
                  next_map_mode = cstx_map_t'(wdata_i[1:0]);
               end
            end
            CSTX_ADDR_WINDOW: next_window = wdata_i[4:0];
            CSTX_ADDR_IRQ_CLR: next_irq_stat = irq_stat & ~{6'h00, wdata_i};
            CSTX_ADDR_IRQ_EN: next_irq_en = {irq_en[13:8], wdata_i};
            default: ;
         endcase
      end
      // Set wins over a clear in the same cycle
      next_irq_stat = next_irq_stat | events;
      // Buffer sources follow their done flags; a fresh completion counts
      next_irq_stat[12:10] = next_irq_stat[12:10]
         & ({txcon[2][7], txcon[1][7], txcon[0][7]} | tx_done_i);
      if (rd_i) begin
         unique case (addr_i)
            CSTX_ADDR_STATUS: begin
               next_rdata[7:5] = opmode;
               if (map_mode == CSTX_MAP_LEGACY) begin
                  // short code, bits 4 and 0 zero
                  next_rdata[3:1] = icode[3:1];
               end else begin
                  next_rdata[4:0] = icode;
               end
            end
            CSTX_ADDR_TXCON0: next_rdata = txcon[0];
            CSTX_ADDR_TXCON1: next_rdata = txcon[1];
            CSTX_ADDR_TXCON2: next_rdata = txcon[2];
            CSTX_ADDR_CONFIG: next_rdata = {mode_req, 3'h0, map_mode};
            CSTX_ADDR_IRQ_STAT: next_rdata = irq_stat[7:0];
            CSTX_ADDR_IRQ_EN: next_rdata = irq_en[7:0];
            CSTX_ADDR_WINDOW: next_rdata = {3'h0, window};
            default: next_rdata = 8'h00;
         endcase
      end
   end

   // High sources (error, transmit, receive) have no software clear here:
   // the 8-bit clear register reaches only the low byte, and transmit bits
   // drop when their buffer's done flag is cleared
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         mode_req <= CSTX_OPMODE_RST;
         map_mode <= CSTX_MAP_LEGACY;
         window   <= 5'h00;
         irq_en   <= 14'h3F00;
         irq_stat <= 14'h0000;
         rdata    <= 8'h00;
         opmode   <= CSTX_OPMODE_RST;
      end else begin
         mode_req <= next_mode_req;
         map_mode <= next_map_mode;
         window   <= next_window;
         irq_en   <= next_irq_en;
         irq_stat <= next_irq_stat;
         rdata    <= next_rdata;
         opmode   <= next_opmode;
      end
   end

   assign rdata_o      = rdata;
   assign mode_req_o   = mode_req;
   assign window_sel_o = window;
   assign irq_o        = |(irq_stat & irq_en);

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   sequence status_read_s;
      rd_i && addr_i == CSTX_ADDR_STATUS && map_mode == CSTX_MAP_LEGACY;
   endsequence
   legacy_code_bits_a: assert property (@(posedge core_clk_i)
      disable iff (sys_rst_i) status_read_s |=> rdata_o[4] == 1'b0
      && rdata_o[0] == 1'b0)
      else $error("legacy code bits not zero");
   error_first_a: assert property (@(posedge core_clk_i)
      disable iff (sys_rst_i) src_en.err |-> icode == CSTX_IC_ERR)
      else $error("error not highest");
   idle_code_a: assert property (@(posedge core_clk_i)
      disable iff (sys_rst_i) (src_en.err | |src_en.tx | src_en.rx0 |
      src_en.rx1 | src_en.wake | |src_en.pb) == 1'b0 |-> icode == 5'h00)
      else $error("idle code not zero");
   // no requested buffer outranks the winner
   send_pick_a: assert property (@(posedge core_clk_i)
      disable iff (sys_rst_i) send_valid_o |-> txcon[send_buf_o][3]
      && !(txcon[0][3] && !abort_req_o[0]
           && txcon[0][1:0] > txcon[send_buf_o][1:0])
      && !(txcon[1][3] && !abort_req_o[1]
           && txcon[1][1:0] > txcon[send_buf_o][1:0])
      && !(txcon[2][3] && !abort_req_o[2]
           && txcon[2][1:0] > txcon[send_buf_o][1:0]))
      else $error("picked buffer not highest priority");
   mode_follow_a: assert property (@(posedge core_clk_i)
      disable iff (sys_rst_i) rd_i && addr_i == CSTX_ADDR_STATUS
      |=> rdata_o[7:5] == $past(opmode))
      else $error("mode field wrong");
   done_sticky_a: assert property (@(posedge core_clk_i)
      disable iff (sys_rst_i) txcon[0][7] && !txcon_wr[0] |=> txcon[0][7])
      else $error("done flag dropped");
   // completion raises the buffer's status bit
   tx_stat_set_a: assert property (@(posedge core_clk_i)
      disable iff (sys_rst_i) |tx_done_i
      |=> (irq_stat[12:10] & $past(tx_done_i)) == $past(tx_done_i))
      else $error("transmit status bit not set");
   sequence fifo_rx_only_s;
      map_mode == CSTX_MAP_FIFO && !src_en.err && src_en.tx == 3'h0
      && !src_en.wake && (src_en.rx0 || src_en.rx1);
   endsequence
   fifo_fold_a: assert property (@(posedge core_clk_i)
      disable iff (sys_rst_i) fifo_rx_only_s |-> icode == CSTX_IC_RX0)
      else $error("FIFO receive code wrong");
   // window select takes the written code
   window_write_a: assert property (@(posedge core_clk_i)
      disable iff (sys_rst_i) wr_i && addr_i == CSTX_ADDR_WINDOW
      |=> {3'h0, window_sel_o} == ($past(wdata_i) & 8'h1F))
      else $error("window select not written");
   // a pending wake source stays until software clears it
   wake_sticky_a: assert property (@(posedge core_clk_i)
      disable iff (sys_rst_i) src.wake
      && !(wr_i && addr_i == CSTX_ADDR_IRQ_CLR && wdata_i[7]) |=> src.wake)
      else $error("wake status dropped");
   // long code fills the low five bits
   long_code_a: assert property (@(posedge core_clk_i)
      disable iff (sys_rst_i) rd_i && addr_i == CSTX_ADDR_STATUS
      && map_mode != CSTX_MAP_LEGACY |=> rdata_o[4:0] == $past(icode))
      else $error("long code not shown");
endmodule // cstx_top

// >>> cstx_pkg.sv
/*
 Package for the bus status and transmit buffer control block.
 Assumes one 100 MHz clock and an 8-bit register port.
*/
package cstx_pkg;
   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam logic [3:0] CSTX_ADDR_STATUS   = 4'h0;
   localparam logic [3:0] CSTX_ADDR_TXCON0   = 4'h1;
   localparam logic [3:0] CSTX_ADDR_TXCON1   = 4'h2;
   localparam logic [3:0] CSTX_ADDR_TXCON2   = 4'h3;
   localparam logic [3:0] CSTX_ADDR_CONFIG   = 4'h4;
   localparam logic [3:0] CSTX_ADDR_IRQ_STAT = 4'h5;
   localparam logic [3:0] CSTX_ADDR_IRQ_CLR  = 4'h6;
   localparam logic [3:0] CSTX_ADDR_IRQ_EN   = 4'h7;
   localparam logic [3:0] CSTX_ADDR_WINDOW   = 4'h8;

   // ------------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------------
   localparam int CSTX_BIT_DONE  = 7;
   localparam int CSTX_BIT_ABORT = 6;
   localparam int CSTX_BIT_LARB  = 5;
   localparam int CSTX_BIT_ERR   = 4;
   localparam int CSTX_BIT_REQ   = 3;
   localparam logic [2:0] CSTX_OPMODE_RST = 3'h4;
   localparam logic [7:0] CSTX_TXCON_RST  = 8'h00;
   localparam int CSTX_NUM_TX = 3;
   localparam int CSTX_NUM_PB = 6;

   typedef enum logic [2:0] {
      CSTX_OP_NORMAL  = 3'b000,
      CSTX_OP_DISABLE = 3'b001,
      CSTX_OP_LOOP    = 3'b010,
      CSTX_OP_LISTEN  = 3'b011,
      CSTX_OP_CONFIG  = 3'b100
   } cstx_opmode_t;

   typedef enum logic [1:0] {
      CSTX_MAP_LEGACY   = 2'b00,
      CSTX_MAP_ENHANCED = 2'b01,
      CSTX_MAP_FIFO     = 2'b10
   } cstx_map_t;

   // Interrupt codes, five-bit view
   localparam logic [4:0] CSTX_IC_NONE  = 5'h00;
   localparam logic [4:0] CSTX_IC_ERR   = 5'h02;
   localparam logic [4:0] CSTX_IC_TX2   = 5'h04;
   localparam logic [4:0] CSTX_IC_TX1   = 5'h06;
   localparam logic [4:0] CSTX_IC_TX0   = 5'h08;
   localparam logic [4:0] CSTX_IC_RX1_L = 5'h0A;
   localparam logic [4:0] CSTX_IC_RX0_L = 5'h0C;
   localparam logic [4:0] CSTX_IC_WAKE  = 5'h0E;
   localparam logic [4:0] CSTX_IC_RX0   = 5'h10;
   localparam logic [4:0] CSTX_IC_RX1   = 5'h11;
   localparam logic [4:0] CSTX_IC_PB0   = 5'h12;

   // Pending interrupt sources
   typedef struct packed {
      logic       err;
      logic [2:0] tx;
      logic       rx1;
      logic       rx0;
      logic       wake;
      logic [5:0] pb;
      logic [5:0] pb_is_tx;
   } cstx_src_t;

   // Engine events for one transmit buffer
   typedef struct packed {
      logic done;
      logic abort;
      logic larb;
      logic err;
   } cstx_txev_t;
endpackage : cstx_pkg

// >>> cstx_icode.sv
/*
 Interrupt code priority encoder.
 Assumes pending levels come from the block's own sticky flags.
*/
module cstx_icode
   import cstx_pkg::*;
(
   input  wire cstx_pkg::cstx_src_t src_i,
   input  wire cstx_pkg::cstx_map_t map_i,
   output logic [4:0]               code_o
);
   // ------------------------------------------------------------------
   // Priority order follows the code table
   // ------------------------------------------------------------------
   always_comb begin
      code_o = CSTX_IC_NONE;
      if (src_i.err) begin
         code_o = CSTX_IC_ERR;
      end else if (src_i.tx[2]) begin
         code_o = CSTX_IC_TX2;
      end else if (src_i.tx[1]) begin
         code_o = CSTX_IC_TX1;
      end else if (src_i.tx[0]) begin
         code_o = CSTX_IC_TX0;
      end else if (map_i == CSTX_MAP_LEGACY) begin
         if (src_i.rx1) begin
            code_o = CSTX_IC_RX1_L;
         end else if (src_i.rx0) begin
            code_o = CSTX_IC_RX0_L;
         end else if (src_i.wake) begin
            code_o = CSTX_IC_ERR;
         end
      end else if (src_i.wake) begin
         code_o = CSTX_IC_WAKE;
      end else if (src_i.rx0) begin
         code_o = CSTX_IC_RX0;
      end else if (src_i.rx1) begin
         code_o = (map_i == CSTX_MAP_FIFO) ? CSTX_IC_RX0 : CSTX_IC_RX1;
      end else begin
         for (int i = CSTX_NUM_PB - 1; i >= 0; i--) begin
            if (src_i.pb[i]) begin
               if (map_i == CSTX_MAP_FIFO && !src_i.pb_is_tx[i]) begin
                  code_o = CSTX_IC_RX0;
               end else begin
                  code_o = CSTX_IC_PB0 + 5'(i);
               end
            end
         end
      end
   end
endmodule // cstx_icode

// >>> cstx_txbuf.sv
/*
 One transmit buffer control register.
 Assumes the engine pulses events only for this buffer while requested.
*/
module cstx_txbuf
   import cstx_pkg::*;
(
   input  wire logic               core_clk_i,
   input  wire logic               sys_rst_i,
   input  wire logic               wr_i,
   input  wire logic [7:0]         wdata_i,
   input  wire cstx_pkg::cstx_txev_t ev_i,
   output logic [7:0]              ctrl_o,
   output logic                    abort_req_o
);
   logic [7:0] ctrl;
   logic [7:0] next_ctrl;
   logic       next_abort_req;
   logic       abort_req;

   always_comb begin
      next_ctrl      = ctrl;
      next_abort_req = abort_req & ctrl[CSTX_BIT_REQ];
      if (wr_i) begin
         if (!wdata_i[CSTX_BIT_DONE]) next_ctrl[CSTX_BIT_DONE] = 1'b0;
         next_ctrl[1:0] = wdata_i[1:0];
         if (wdata_i[CSTX_BIT_REQ] && !ctrl[CSTX_BIT_REQ]) begin
            next_ctrl[CSTX_BIT_REQ]   = 1'b1;
            next_ctrl[CSTX_BIT_ABORT] = 1'b0;
            next_ctrl[CSTX_BIT_LARB]  = 1'b0;
            next_ctrl[CSTX_BIT_ERR]   = 1'b0;
         end else if (!wdata_i[CSTX_BIT_REQ] && ctrl[CSTX_BIT_REQ]) begin
            next_abort_req = 1'b1;
         end
      end
      // Events after the write so hardware sets win over clears
      if (ev_i.larb) next_ctrl[CSTX_BIT_LARB] = 1'b1;
      if (ev_i.err) next_ctrl[CSTX_BIT_ERR] = 1'b1;
      if (ev_i.done) begin
         next_ctrl[CSTX_BIT_DONE] = 1'b1;
         next_ctrl[CSTX_BIT_REQ]  = 1'b0;
         next_abort_req           = 1'b0;
      end
      if (ev_i.abort) begin
         next_ctrl[CSTX_BIT_ABORT] = 1'b1;
         next_ctrl[CSTX_BIT_REQ]   = 1'b0;
         next_abort_req            = 1'b0;
      end
      next_ctrl[2] = 1'b0;
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ctrl      <= CSTX_TXCON_RST;
         abort_req <= 1'b0;
      end else begin
         ctrl      <= next_ctrl;
         abort_req <= next_abort_req;
      end
   end

   assign ctrl_o      = ctrl;
   assign abort_req_o = abort_req;

   done_clears_req_a: assert property (@(posedge core_clk_i)
      disable iff (sys_rst_i) ev_i.done |=> !ctrl[CSTX_BIT_REQ]
      && ctrl[CSTX_BIT_DONE])
      else $error("done did not end request");
   bit_two_zero_a: assert property (@(posedge core_clk_i)
      disable iff (sys_rst_i) ctrl[2] == 1'b0)
      else $error("bit 2 not zero");
endmodule // cstx_txbuf

// >>> cstx_engine_model.sv
/*
 Bus engine model for the transmit buffer control block.
 Assumes the bench steers go, outcome and delay of each transfer.
*/
module cstx_engine_model (
   input  wire logic       core_clk_i,
   input  wire logic       sys_rst_i,
   input  wire logic       go_i,
   input  wire logic [1:0] outcome_i,
   input  wire logic [3:0] dly_i,
   input  wire logic       send_valid_i,
   input  wire logic [1:0] send_buf_i,
   input  wire logic [2:0] abort_req_i,
   input  wire logic [2:0] mode_req_i,
   output logic      [2:0] tx_done_o,
   output logic      [2:0] tx_abort_o,
   output logic      [2:0] tx_larb_o,
   output logic      [2:0] tx_err_o,
   output logic      [2:0] mode_status_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       busy;
   logic       held;
   logic [1:0] cur;
   logic [3:0] cnt;
   logic [2:0] abort_q;
   // ------------------------------------------------------------------
   // Engine
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         {busy, held, cur, cnt, abort_q} <= '0;
         {tx_done_o, tx_abort_o, tx_larb_o, tx_err_o} <= '0;
         mode_status_o <= 3'h4;
      end else begin
         {tx_done_o, tx_larb_o, tx_err_o} <= '0;
         mode_status_o <= mode_req_i;
         abort_q <= abort_req_i;
         tx_abort_o <= abort_req_i & ~abort_q;
         if (held) begin
            // Failed buffer waits here so it is not retried forever
            if (abort_req_i[cur]) begin
               busy <= 1'b0;
               held <= 1'b0;
            end
         end else if (busy) begin
            cnt <= cnt - 4'h1;
            if (cnt == 4'h0) begin
               busy <= (outcome_i != 2'h0);
               held <= (outcome_i != 2'h0);
               tx_done_o[cur] <= (outcome_i == 2'h0);
               tx_larb_o[cur] <= (outcome_i == 2'h1);
               tx_err_o[cur]  <= (outcome_i == 2'h2);
            end
         end else if (go_i && send_valid_i
                      && !(|{tx_done_o, tx_abort_o})) begin
            busy <= 1'b1;
            cur  <= send_buf_i;
            cnt  <= dly_i;
         end
      end
   end
endmodule // cstx_engine_model

// >>> can_status_and_tx_buffer_control_bench.sv
/*
 Self-checking bench for the status and transmit buffer control block.
 Assumes the engine model answers on the far side of the block.
*/
module can_status_and_tx_buffer_control_bench
   import cstx_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk, rst, wr, rd, go, e_irq, w_irq, r0_irq, r1_irq;
   logic       send_valid, irq;
   logic [3:0] addr, dly;
   logic [7:0] wdata, rdata;
   logic [1:0] outcome, send_buf;
   logic [5:0] pb_irq, pb_is_tx;
   logic [2:0] done_e, abort_e, larb_e, terr_e, mode_st, mode_req, ab_req;
   logic [4:0] win;
   int         error_cnt, n_compared, cyc;
   logic [2:0] modes [5] = '{3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
   logic [7:0] prio [5] = '{8'h61, 8'hE8, 8'h6A, 8'h02, 8'hCE};
   logic [4:0] wake_c [4] = '{5'h02, 5'h0E, 5'h0E, 5'h0E};
   cstx_top DUT (.core_clk_i(clk), .sys_rst_i(rst), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
      .tx_done_i(done_e), .tx_abort_i(abort_e), .tx_larb_i(larb_e),
      .tx_err_i(terr_e), .err_irq_i(e_irq), .wake_irq_i(w_irq),
      .rx0_irq_i(r0_irq), .rx1_irq_i(r1_irq), .pb_irq_i(pb_irq),
      .pb_is_tx_i(pb_is_tx), .mode_status_i(mode_st), .mode_req_o(mode_req),
      .send_valid_o(send_valid), .send_buf_o(send_buf),
      .abort_req_o(ab_req), .window_sel_o(win), .irq_o(irq));
   cstx_engine_model u_eng (.core_clk_i(clk), .sys_rst_i(rst), .go_i(go),
      .outcome_i(outcome), .dly_i(dly), .send_valid_i(send_valid),
      .send_buf_i(send_buf), .abort_req_i(ab_req), .mode_req_i(mode_req),
      .tx_done_o(done_e), .tx_abort_o(abort_e), .tx_larb_o(larb_e),
      .tx_err_o(terr_e), .mode_status_o(mode_st));
   // ------------------------------------------------------------------
   // Clock, timeout and tasks
   // ------------------------------------------------------------------
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         error_cnt++;
         summarize();
      end
   end
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, g);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rchk(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk($sformatf("reg %h", a), e, rdata);
   endtask
   task automatic mchk(input logic [1:0] m, input logic [4:0] c);
      wr_reg(4'h4, {6'h00, m});
      rchk(4'h0, {3'h0, c});
   endtask
   task automatic pulse(input logic [9:0] v);
      @(posedge clk);
      {e_irq, w_irq, r1_irq, r0_irq, pb_irq} <= v;
      @(posedge clk);
      {e_irq, w_irq, r1_irq, r0_irq, pb_irq} <= 10'h000;
   endtask
   // ------------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------------
   initial begin
      {clk, wr, rd, go, outcome, addr, wdata, error_cnt, n_compared} = '0;
      {e_irq, w_irq, r0_irq, r1_irq, pb_irq, cyc} = '0;
      {rst, dly, pb_is_tx} = {1'b1, 4'h3, 6'h05};
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      rchk(4'h0, 8'h80);
      for (int i = 1; i < 4; i++) rchk(i[3:0], 8'h00);
      rchk(4'hF, 8'h00);
      chk("irq", 8'h00, {7'h00, irq});
      $display("test reset done");
      foreach (modes[i]) begin
         wr_reg(4'h4, {modes[i], 5'h00});
         repeat (4) @(posedge clk);
         rchk(4'h0, {modes[i], 5'h00});
      end
      $display("test modes done");
      go <= 1'b1;
      wr_reg(4'h1, 8'h0B);
      chk("send", 8'h10, {3'h0, send_valid, 2'h0, send_buf});
      repeat (12) @(posedge clk);
      rchk(4'h1, 8'h83);
      chk("irq", 8'h01, {7'h00, irq});
      rchk(4'h0, 8'h08);
      wr_reg(4'h8, 8'h08);
      chk("window", 8'h08, {3'h0, win});
      wr_reg(4'h1, 8'hF7);
      rchk(4'h1, 8'h83);
      wr_reg(4'h1, 8'h74);
      rchk(4'h1, 8'h00);
      chk("irq", 8'h00, {7'h00, irq});
      $display("test send done");
      for (int n = 1; n < 3; n++) begin
         {outcome, dly} <= {n[1:0], (n == 2) ? 4'h9 : 4'h2};
         wr_reg(n + 1, 8'h08);
         repeat (20) @(posedge clk);
         rchk(n + 1, (n == 1) ? 8'h28 : 8'h18);
         wr_reg(n + 1, 8'h00);
         repeat (6) @(posedge clk);
         rchk(n + 1, (n == 1) ? 8'h60 : 8'h50);
         outcome <= 2'h0;
         wr_reg(n + 1, 8'h08);
         repeat (20) @(posedge clk);
         rchk(n + 1, 8'h80);
         wr_reg(n + 1, 8'h00);
      end
      $display("test faults done");
      {go, dly} <= {1'b0, 4'h3};
      foreach (prio[k]) begin
         for (int b = 0; b < 3; b++) wr_reg(b+1, {6'h02, prio[k][7-2*b -: 2]});
         chk("order", {6'h00, prio[k][1:0]}, {6'h00, send_buf});
      end
      go <= 1'b1;
      repeat (60) @(posedge clk);
      rchk(4'h0, 8'h04);
      wr_reg(4'h3, 8'h00);
      rchk(4'h0, 8'h06);
      wr_reg(4'h2, 8'h00);
      rchk(4'h0, 8'h08);
      wr_reg(4'h1, 8'h00);
      rchk(4'h0, 8'h00);
      $display("test priority done");
      wr_reg(4'h7, 8'h00);
      pulse(10'h100);
      rchk(4'h5, 8'h80);
      rchk(4'h0, 8'h00);
      chk("irq", 8'h00, {7'h00, irq});
      wr_reg(4'h7, 8'hFF);
      chk("irq", 8'h01, {7'h00, irq});
      foreach (wake_c[m]) mchk(m[1:0], wake_c[m]);
      wr_reg(4'h6, 8'h80);
      rchk(4'h5, 8'h00);
      chk("irq", 8'h00, {7'h00, irq});
      for (int i = 0; i < 6; i++) begin
         pulse(10'h001 << i);
         mchk(2'h1, 5'h12 + i[4:0]);
         mchk(2'h2, pb_is_tx[i] ? 5'h12 + i[4:0] : 5'h10);
         wr_reg(4'h6, 8'h01 << i);
      end
      $display("test codes done");
      pulse(10'h040);
      mchk(2'h0, 5'h0C);
      mchk(2'h1, 5'h10);
      mchk(2'h2, 5'h10);
      pulse(10'h080);
      mchk(2'h0, 5'h0A);
      mchk(2'h2, 5'h10);
      pulse(10'h200);
      mchk(2'h0, 5'h02);
      mchk(2'h1, 5'h02);
      $display("test receivers done");
      summarize();
   end
endmodule // can_status_and_tx_buffer_control_bench
